// ---- dbs_sram_port.sv ----
// Link-side logic of a burst-of-two separate-I/O static memory with trace stream.
// Assumes k_clk_i is the input clock, its inverse is taken as the falling edge,
// and the output clock pair, when it toggles, is in phase with the input pair.
module dbs_sram_port
  import dbs_pkg::*;
#(
  parameter int DW = DATA_W,
  parameter int AW = ADDR_W,
  parameter int FD = FIFO_DEPTH
) (
  input wire logic mclk_i, // System clock.
  input wire logic rstn_i, // Asynchronous reset, active low.
  input wire logic k_clk_i, // Link input clock, falling edge stands for its inverse.
  input wire logic load_select_n_i, // Command load, active low.
  input wire logic read_not_write_i, // Access type, high reads.
  input wire logic [AW-1:0] addr_in_i, // Burst address.
  input wire logic [DW-1:0] d_i, // Write data.
  input wire logic [NBYTE-1:0] byte_write_n_i, // Byte write mask, active low.
  input wire logic c_pos_i, // Output clock.
  input wire logic c_neg_i, // Inverted output clock.
  input wire logic dll_off_n_i, // Loop disable, active low.
  output logic [DW-1:0] q_o, // Read data.
  output logic q_oe_o, // High while read data is driven.
  output logic echo_strobe_pos_o, // Echo clock.
  output logic echo_strobe_neg_o, // Inverted echo clock.
  output logic trace_valid_o, // Committed write available.
  input wire logic trace_ready_i, // Trace consumer ready.
  output dbs_trace_s trace_o, // Committed write record.
  output logic trace_lost_o // Sticky, a record was dropped.
);

  localparam int PW = (FD > 1) ? $clog2(FD) : 1;
  localparam int CW = $clog2(FD + 1);

  function automatic logic [DW-1:0] merge(input logic [DW-1:0] old_w,
                                           input logic [DW-1:0] new_w,
                                           input logic [NBYTE-1:0] mask_n);
    logic [DW-1:0] res;
    res = old_w;
    for (int b = 0; b < NBYTE; b++) begin
      if (!mask_n[b]) begin
        res[b*BYTE_W +: BYTE_W] = new_w[b*BYTE_W +: BYTE_W];
      end
    end
    return res;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Reset synchronisers, one per domain.

  logic [SYNC_STAGES-1:0] m_rst_q;
  logic [SYNC_STAGES-1:0] k_rst_q;
  logic mrstn;
  logic krstn;

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      m_rst_q <= '0;
    end else begin
      m_rst_q <= {m_rst_q[SYNC_STAGES-2:0], 1'b1};
    end
  end

  always_ff @(posedge k_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      k_rst_q <= '0;
    end else begin
      k_rst_q <= {k_rst_q[SYNC_STAGES-2:0], 1'b1};
    end
  end

  assign mrstn = m_rst_q[SYNC_STAGES-1];
  assign krstn = k_rst_q[SYNC_STAGES-1];

  ////////////////////////////////////////////////////////////////////////////
  // Static mode pins, synchronised into the link domain.

  logic [SYNC_STAGES-1:0] doff_sync_q;
  logic [SYNC_STAGES-1:0] ctie_sync_q;
  logic dll_off;
  logic use_k;

  always_ff @(posedge k_clk_i or negedge krstn) begin
    if (!krstn) begin
      doff_sync_q <= '1;
      ctie_sync_q <= '0;
    end else begin
      doff_sync_q <= {doff_sync_q[SYNC_STAGES-2:0], dll_off_n_i};
      ctie_sync_q <= {ctie_sync_q[SYNC_STAGES-2:0], c_pos_i & c_neg_i};
    end
  end

  assign dll_off = !doff_sync_q[SYNC_STAGES-1];
  assign use_k = ctie_sync_q[SYNC_STAGES-1];

  ////////////////////////////////////////////////////////////////////////////
  // Input registers on both edges of the input clock.

  dbs_cmd_s cmd_q;
  logic [AW-1:0] addr_q;
  logic [DW-1:0] in_d0_q;
  logic [NBYTE-1:0] in_bw0_q;
  logic [DW-1:0] in_d1_q;
  logic [NBYTE-1:0] in_bw1_q;
  logic rd_cmd;
  logic wr_cmd;

  always_ff @(posedge k_clk_i or negedge krstn) begin
    if (!krstn) begin
      cmd_q <= '0;
      addr_q <= ADDR_RST_VAL;
      in_d0_q <= Q_RST_VAL;
      in_bw0_q <= MASK_RST_VAL;
    end else begin
      cmd_q.load <= !load_select_n_i;
      cmd_q.read <= read_not_write_i;
      addr_q <= addr_in_i;
      in_d0_q <= d_i;
      in_bw0_q <= byte_write_n_i;
    end
  end

  always_ff @(negedge k_clk_i or negedge krstn) begin
    if (!krstn) begin
      in_d1_q <= Q_RST_VAL;
      in_bw1_q <= MASK_RST_VAL;
    end else begin
      in_d1_q <= d_i;
      in_bw1_q <= byte_write_n_i;
    end
  end

  assign rd_cmd = cmd_q.load && cmd_q.read;
  assign wr_cmd = cmd_q.load && !cmd_q.read;

  ////////////////////////////////////////////////////////////////////////////
  // Late write buffer and array.

  logic wb_vld_q;
  logic [AW-1:0] wb_addr_q;
  logic [DW-1:0] mem_q [2**(AW+1)];

  always_ff @(posedge k_clk_i or negedge krstn) begin
    if (!krstn) begin
      wb_vld_q <= 1'b0;
      wb_addr_q <= ADDR_RST_VAL;
    end else begin
      wb_vld_q <= wr_cmd;
      wb_addr_q <= addr_q;
    end
  end

  always_ff @(posedge k_clk_i) begin
    if (wb_vld_q) begin
      mem_q[{wb_addr_q, 1'b0}] <= merge(mem_q[{wb_addr_q, 1'b0}], in_d0_q, in_bw0_q);
      mem_q[{wb_addr_q, 1'b1}] <= merge(mem_q[{wb_addr_q, 1'b1}], in_d1_q, in_bw1_q);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read fetch with forwarding from the write that commits on the same edge.

  logic hit;
  logic [DW-1:0] fetch_w0;
  logic [DW-1:0] fetch_w1;
  logic rd_stage_q;
  logic [DW-1:0] rd_w0_q;
  logic [DW-1:0] rd_w1_q;

  assign hit = wb_vld_q && (wb_addr_q == addr_q);
  assign fetch_w0 = hit ? merge(mem_q[{addr_q, 1'b0}], in_d0_q, in_bw0_q)
                        : mem_q[{addr_q, 1'b0}];
  assign fetch_w1 = hit ? merge(mem_q[{addr_q, 1'b1}], in_d1_q, in_bw1_q)
                        : mem_q[{addr_q, 1'b1}];

  always_ff @(posedge k_clk_i or negedge krstn) begin
    if (!krstn) begin
      rd_stage_q <= 1'b0;
      rd_w0_q <= Q_RST_VAL;
      rd_w1_q <= Q_RST_VAL;
    end else begin
      rd_stage_q <= rd_cmd;
      if (rd_cmd) begin
        rd_w0_q <= fetch_w0;
        rd_w1_q <= fetch_w1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Double data rate output registers and echo clocks.

  logic [DW-1:0] q_pos_q;
  logic q_pos_vld_q;
  logic [DW-1:0] q_neg_q;
  logic q_neg_vld_q;
  logic out_phase;

  always_ff @(posedge k_clk_i or negedge krstn) begin
    if (!krstn) begin
      q_pos_q <= Q_RST_VAL;
      q_pos_vld_q <= 1'b0;
    end else if (dll_off && rd_cmd) begin
      q_pos_q <= fetch_w0;
      q_pos_vld_q <= 1'b1;
    end else if (!dll_off && rd_stage_q) begin
      q_pos_q <= rd_w1_q;
      q_pos_vld_q <= 1'b1;
    end else begin
      q_pos_vld_q <= 1'b0;
    end
  end

  always_ff @(negedge k_clk_i or negedge krstn) begin
    if (!krstn) begin
      q_neg_q <= Q_RST_VAL;
      q_neg_vld_q <= 1'b0;
    end else if (rd_stage_q) begin
      q_neg_q <= dll_off ? rd_w1_q : rd_w0_q;
      q_neg_vld_q <= 1'b1;
    end else begin
      q_neg_vld_q <= 1'b0;
    end
  end

  assign out_phase = use_k ? k_clk_i : c_pos_i;
  assign q_o = out_phase ? q_pos_q : q_neg_q;
  assign q_oe_o = out_phase ? q_pos_vld_q : q_neg_vld_q;
  assign echo_strobe_pos_o = use_k ? k_clk_i : c_pos_i;
  assign echo_strobe_neg_o = use_k ? !k_clk_i : c_neg_i;

  ////////////////////////////////////////////////////////////////////////////
  // Trace of committed writes, handed to the system clock by a toggle handshake.

  dbs_trace_s tr_word_q;
  logic tr_req_q;
  logic tr_lost_q;
  logic [SYNC_STAGES-1:0] ack_sync_q;
  logic [SYNC_STAGES-1:0] req_sync_q;
  logic [SYNC_STAGES-1:0] lost_sync_q;
  logic m_ack_q;
  logic push;
  logic fifo_ready;

  always_ff @(posedge k_clk_i or negedge krstn) begin
    if (!krstn) begin
      tr_word_q <= '0;
      tr_req_q <= 1'b0;
      tr_lost_q <= 1'b0;
      ack_sync_q <= '0;
    end else begin
      ack_sync_q <= {ack_sync_q[SYNC_STAGES-2:0], m_ack_q};
      if (wb_vld_q) begin
        if (tr_req_q == ack_sync_q[SYNC_STAGES-1]) begin
          tr_word_q <= '{addr: wb_addr_q, mask_n: {in_bw1_q, in_bw0_q},
                         word1: in_d1_q, word0: in_d0_q};
          tr_req_q <= !tr_req_q;
        end else begin
          tr_lost_q <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge mclk_i or negedge mrstn) begin
    if (!mrstn) begin
      req_sync_q <= '0;
      lost_sync_q <= '0;
      m_ack_q <= 1'b0;
    end else begin
      req_sync_q <= {req_sync_q[SYNC_STAGES-2:0], tr_req_q};
      lost_sync_q <= {lost_sync_q[SYNC_STAGES-2:0], tr_lost_q};
      if (push) begin
        m_ack_q <= !m_ack_q;
      end
    end
  end

  // The acknowledge waits for buffer space, so a stalled consumer makes the source drop later records and set the lost flag.
  assign push = (req_sync_q[SYNC_STAGES-1] != m_ack_q) && fifo_ready;
  assign trace_lost_o = lost_sync_q[SYNC_STAGES-1];

  ////////////////////////////////////////////////////////////////////////////
  // Two-entry trace buffer.

  dbs_trace_s fifo_q [FD];
  logic [PW-1:0] wptr_q;
  logic [PW-1:0] rptr_q;
  logic [CW-1:0] cnt_q;
  logic pop;

  assign fifo_ready = cnt_q != CW'(FD);
  assign trace_valid_o = cnt_q != '0;
  assign pop = trace_valid_o && trace_ready_i;
  assign trace_o = fifo_q[rptr_q];

  always_ff @(posedge mclk_i or negedge mrstn) begin
    if (!mrstn) begin
      wptr_q <= '0;
      rptr_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wptr_q <= (wptr_q == PW'(FD - 1)) ? '0 : wptr_q + 1'b1;
      end
      if (pop) begin
        rptr_q <= (rptr_q == PW'(FD - 1)) ? '0 : rptr_q + 1'b1;
      end
      if (push && !pop) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (pop && !push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (push) begin
      fifo_q[wptr_q] <= tr_word_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  property p_decode_read;
    @(posedge k_clk_i) disable iff (!krstn)
      (!load_select_n_i && read_not_write_i) |=> rd_cmd;
  endproperty
  a_decode_read: assert property (p_decode_read)
    else $error("Read command not decoded.");

  property p_deselect;
    @(posedge k_clk_i) disable iff (!krstn)
      load_select_n_i |=> !rd_cmd && !wr_cmd ##1 !wb_vld_q && !rd_stage_q;
  endproperty
  a_deselect: assert property (p_deselect)
    else $error("Deselected cycle started an access.");

  property p_write_buffer;
    @(posedge k_clk_i) disable iff (!krstn)
      (!load_select_n_i && !read_not_write_i) |=> ##1 (wb_vld_q && wb_addr_q == $past(addr_in_i, 2));
  endproperty
  a_write_buffer: assert property (p_write_buffer)
    else $error("Write address not held for late data.");

  property p_byte_merge;
    @(posedge k_clk_i) disable iff (!krstn)
      wb_vld_q |=> mem_q[{$past(wb_addr_q), 1'b1}] ==
                   merge($past(mem_q[{wb_addr_q, 1'b1}]), $past(in_d1_q), $past(in_bw1_q));
  endproperty
  a_byte_merge: assert property (p_byte_merge)
    else $error("Second word bytes written against mask.");

  property p_read_norm;
    @(posedge k_clk_i) disable iff (!krstn)
      (rd_cmd && !dll_off) ##1 !dll_off |=> q_pos_vld_q && q_pos_q == $past(fetch_w1, 2);
  endproperty
  a_read_norm: assert property (p_read_norm)
    else $error("Second read word not at third rising edge.");

  property p_read_first;
    @(posedge k_clk_i) disable iff (!krstn)
      (rd_cmd && !dll_off) |=> (q_neg_vld_q && q_neg_q == $past(fetch_w0));
  endproperty
  a_read_first: assert property (p_read_first)
    else $error("First read word not driven at 1.5 cycles.");

  property p_read_dll_off;
    @(posedge k_clk_i) disable iff (!krstn)
      (rd_cmd && dll_off) |=> q_pos_vld_q && q_pos_q == $past(fetch_w0);
  endproperty
  a_read_dll_off: assert property (p_read_dll_off)
    else $error("One-cycle latency mode mistimed.");

  property p_coherent;
    @(posedge k_clk_i) disable iff (!krstn)
      (rd_cmd && hit) |=> rd_w0_q == merge($past(mem_q[{addr_q, 1'b0}]),
                                           $past(in_d0_q), $past(in_bw0_q));
  endproperty
  a_coherent: assert property (p_coherent)
    else $error("Read missed a pending write.");

  property p_echo;
    @(posedge k_clk_i) disable iff (!krstn)
      use_k |-> !echo_strobe_pos_o && echo_strobe_neg_o;
  endproperty
  a_echo: assert property (p_echo)
    else $error("Echo clocks not complementary.");

  property p_trace_hold;
    @(posedge mclk_i) disable iff (!mrstn)
      (trace_valid_o && !trace_ready_i) |=> trace_valid_o && $stable(trace_o);
  endproperty
  a_trace_hold: assert property (p_trace_hold)
    else $error("Trace record changed while stalled.");

  c_read: cover property (@(posedge k_clk_i) disable iff (!krstn) rd_cmd ##2 q_pos_vld_q);
  c_write: cover property (@(posedge k_clk_i) disable iff (!krstn) wr_cmd ##1 wb_vld_q);
  c_forward: cover property (@(posedge k_clk_i) disable iff (!krstn) rd_cmd && hit);
  c_stall: cover property (@(posedge mclk_i) disable iff (!mrstn) !fifo_ready && !trace_ready_i);

endmodule

// ---- dbs_pkg.sv ----
// Shared constants and carriers for the burst-of-two separate-I/O SRAM port.
// Assumes the top module takes its widths from the defaults held here.
package dbs_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Geometry: 1M x 18 by default; 512K x 36 uses DATA_W 36 and ADDR_W 18.

  localparam int DATA_W = 18;
  localparam int ADDR_W = 19;
  localparam int BYTE_W = 9;
  localparam int BURST_LEN = 2;
  localparam int NBYTE = DATA_W / BYTE_W;

  ////////////////////////////////////////////////////////////////////////////
  // Crossing and buffering.

  localparam int SYNC_STAGES = 2;
  localparam int FIFO_DEPTH = 2;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values.

  localparam logic [DATA_W-1:0] Q_RST_VAL = 18'h00000;
  localparam logic [ADDR_W-1:0] ADDR_RST_VAL = 19'h00000;
  localparam logic [NBYTE-1:0] MASK_RST_VAL = 2'h3;

  ////////////////////////////////////////////////////////////////////////////
  // Carriers.

  typedef struct packed {
    logic load;
    logic read;
  } dbs_cmd_s;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [BURST_LEN*NBYTE-1:0] mask_n;
    logic [DATA_W-1:0] word1;
    logic [DATA_W-1:0] word0;
  } dbs_trace_s;

endpackage

// ---- dbs_host_model.sv ----
// Host memory controller model that drives the link command and write data pins.
// Assumes one thread calls issue or idle once per link cycle, starting after reset.
module dbs_host_model
  import dbs_pkg::*;
(
  input wire logic k_clk_i, // Link input clock.
  output logic load_select_n_o, // Command load, active low.
  output logic read_not_write_o, // Access type, high reads.
  output logic [ADDR_W-1:0] addr_o, // Burst address.
  output logic [DATA_W-1:0] d_o, // Write data.
  output logic [NBYTE-1:0] byte_write_n_o // Byte write mask, active low.
);
  timeunit 1ns;
  timeprecision 100ps;

  int wr_pend = 0;

  initial begin
    load_select_n_o = 1'b1;
    read_not_write_o = 1'b1;
    addr_o = '0;
    d_o = '0;
    byte_write_n_o = '1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // One command per rising edge; write words follow one cycle late.
  task automatic issue(input logic rnw, input logic [ADDR_W-1:0] a,
                       input logic [DATA_W-1:0] w0, input logic [DATA_W-1:0] w1,
                       input logic [NBYTE-1:0] m0, input logic [NBYTE-1:0] m1);
    @(posedge k_clk_i);
    #1;
    load_select_n_o = 1'b0;
    read_not_write_o = rnw;
    addr_o = a;
    if (!rnw) begin
      wr_pend++;
      fork
        begin
          @(posedge k_clk_i);
          @(negedge k_clk_i);
          #1;
          d_o = w0;
          byte_write_n_o = m0;
          @(posedge k_clk_i);
          #1;
          d_o = w1;
          byte_write_n_o = m1;
          @(negedge k_clk_i);
          #1;
          wr_pend--;
          // A following write owns the pins now, so only an idle host releases.
          if (wr_pend == 0) begin
            d_o = ~d_o;
            byte_write_n_o = ~byte_write_n_o;
          end
        end
      join_none
    end
  endtask

  // Deselected cycle: address and access type are scrambled and must be ignored.
  task automatic idle();
    @(posedge k_clk_i);
    #1;
    load_select_n_o = 1'b1;
    read_not_write_o = ~read_not_write_o;
    addr_o = ~addr_o;
  endtask

endmodule

// ---- dbs_sram_port_test.sv ----
// Self-checking bench for the burst-of-two SRAM port against a queue-based model.
// Assumes the package defaults; output clocks are tied high, then follow K in the last phase.
`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin n_fail++; \
  $display("[FAIL] %s expected %h seen %h", nm, ex, got); end end

module dbs_sram_port_test
  import dbs_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic mclk_i = 1'b0;
  logic k_clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic dll_off_n_i = 1'b1;
  logic trace_ready_i = 1'b0;
  logic stall = 1'b0;
  logic c_tie = 1'b1;
  logic load_n, rnw, q_oe, e_pos, e_neg, t_valid, t_lost;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] d, q;
  logic [NBYTE-1:0] bwn;
  dbs_trace_s t_rec;
  int n_fail = 0;
  int check_count = 0;
  int seed = 32'h79e1;
  logic [DATA_W-1:0] mem [logic [ADDR_W:0]];
  dbs_trace_s exp_q[$];
  logic [ADDR_W-1:0] addrs [4];

  always #2 mclk_i = ~mclk_i;
  initial begin
    #1.3;
    forever #6 k_clk_i = ~k_clk_i;
  end

  dbs_host_model i_dbs_host_model (.k_clk_i(k_clk_i), .load_select_n_o(load_n),
    .read_not_write_o(rnw), .addr_o(addr), .d_o(d), .byte_write_n_o(bwn));

  dbs_sram_port i_dbs_sram_port (.mclk_i(mclk_i), .rstn_i(rstn_i), .k_clk_i(k_clk_i),
    .load_select_n_i(load_n), .read_not_write_i(rnw), .addr_in_i(addr), .d_i(d),
    .byte_write_n_i(bwn), .c_pos_i(c_tie | k_clk_i), .c_neg_i(c_tie | !k_clk_i),
    .dll_off_n_i(dll_off_n_i),
    .q_o(q), .q_oe_o(q_oe), .echo_strobe_pos_o(e_pos), .echo_strobe_neg_o(e_neg),
    .trace_valid_o(t_valid), .trace_ready_i(trace_ready_i), .trace_o(t_rec),
    .trace_lost_o(t_lost));

  ////////////////////////////////////////////////////////////////////////////
  // Model helpers.
  function automatic logic [DATA_W-1:0] rnd();
    return DATA_W'($random(seed));
  endfunction

  function automatic logic [DATA_W-1:0] bytes_en(input logic [NBYTE-1:0] m_n);
    logic [DATA_W-1:0] en;
    for (int b = 0; b < NBYTE; b++) en[b*BYTE_W +: BYTE_W] = {BYTE_W{~m_n[b]}};
    return en;
  endfunction

  function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] old,
      input logic [DATA_W-1:0] nw, input logic [NBYTE-1:0] m_n);
    return (old & ~bytes_en(m_n)) | (nw & bytes_en(m_n));
  endfunction

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] w0,
                    input logic [DATA_W-1:0] w1, input logic [NBYTE-1:0] m0,
                    input logic [NBYTE-1:0] m1);
    mem[{a, 1'b0}] = merge(mem[{a, 1'b0}], w0, m0);
    mem[{a, 1'b1}] = merge(mem[{a, 1'b1}], w1, m1);
    exp_q.push_back(dbs_trace_s'{addr: a, mask_n: {m1, m0}, word1: w1, word0: w0});
    i_dbs_host_model.issue(1'b0, a, w0, w1, m0, m1);
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a);
    logic [DATA_W-1:0] w0, w1;
    logic slow;
    w0 = mem[{a, 1'b0}];
    w1 = mem[{a, 1'b1}];
    slow = dll_off_n_i;
    i_dbs_host_model.issue(1'b1, a, '0, '0, '0, '0);
    fork
      begin
        @(posedge k_clk_i);
        @(posedge k_clk_i);
        if (slow) @(negedge k_clk_i);
        #2;
        `CHK("read word0", w0, q)
        `CHK("read valid0", 1'b1, q_oe)
        `CHK("echo pos", k_clk_i, e_pos)
        if (slow) @(posedge k_clk_i); else @(negedge k_clk_i);
        #2;
        `CHK("read word1", w1, q)
        `CHK("read valid1", 1'b1, q_oe)
        `CHK("echo neg", ~k_clk_i, e_neg)
      end
    join_none
  endtask

  task automatic gap(input int n);
    repeat (n) i_dbs_host_model.idle();
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Trace stream: random back-pressure, records checked in commit order.
  always @(posedge mclk_i) begin
    #1;
    trace_ready_i <= !stall && (($random(seed) & 3) != 0);
  end

  always @(negedge mclk_i) begin
    if (rstn_i && t_valid === 1'b1 && trace_ready_i) check_trace(t_rec);
  end

  task automatic check_trace(input dbs_trace_s r);
    dbs_trace_s e;
    int skip;
    skip = 0;
    while (exp_q.size() > 1 && {exp_q[0].addr, exp_q[0].mask_n} !== {r.addr, r.mask_n}) begin
      void'(exp_q.pop_front());
      skip++;
    end
    e = (exp_q.size() > 0) ? exp_q.pop_front() : '0;
    `CHK("trace addr", e.addr, r.addr)
    `CHK("trace mask", e.mask_n, r.mask_n)
    `CHK("trace word0", e.word0 & bytes_en(e.mask_n[1:0]), r.word0 & bytes_en(r.mask_n[1:0]))
    `CHK("trace word1", e.word1 & bytes_en(e.mask_n[3:2]), r.word1 & bytes_en(r.mask_n[3:2]))
    if (skip > 0) `CHK("lost flag", 1'b1, t_lost)
  endtask

  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  initial begin
    #60000;
    n_fail++;
    give_verdict();
  end

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial begin
    for (int i = 0; i < 4; i++) addrs[i] = ADDR_W'($random(seed));
    repeat (4) @(posedge k_clk_i);
    #1;
    rstn_i = 1'b1;
    repeat (8) @(posedge k_clk_i);
    // Spaced full writes and reads, one trace record at a time.
    for (int i = 0; i < 4; i++) begin
      wr(addrs[i], rnd(), rnd(), 2'h0, 2'h0);
      gap(10);
      rd(addrs[i]);
      gap(4);
    end
    `CHK("idle valid", 1'b0, q_oe)
    `CHK("no loss", 1'b0, t_lost)
    // Every byte mask code on both words.
    for (int i = 0; i < 16; i++) begin
      wr(addrs[i % 4], rnd(), rnd(), NBYTE'(i), NBYTE'(i >> 2));
      gap(10);
      rd(addrs[i % 4]);
      gap(4);
    end
    // Back-to-back mixes with the trace consumer stalled.
    stall = 1'b1;
    for (int i = 0; i < 4; i++) begin
      wr(addrs[i], rnd(), rnd(), NBYTE'($random(seed)), NBYTE'($random(seed)));
      rd(addrs[i]);
      rd(addrs[(i + 1) % 4]);
      wr(addrs[(i + 2) % 4], rnd(), rnd(), 2'h1, 2'h2);
      wr(addrs[(i + 3) % 4], rnd(), rnd(), 2'h2, 2'h0);
      rd(addrs[(i + 3) % 4]);
    end
    gap(20);
    stall = 1'b0;
    gap(30);
    // Everything still queued here was dropped by the busy handshake, not delivered.
    exp_q.delete();
    // One-cycle latency mode.
    dll_off_n_i = 1'b0;
    c_tie = 1'b0;
    gap(6);
    for (int i = 0; i < 4; i++) begin
      wr(addrs[i], rnd(), rnd(), NBYTE'($random(seed)), 2'h0);
      rd(addrs[i]);
      rd(addrs[(i + 1) % 4]);
    end
    gap(30);
    `CHK("trace drained", 1'b0, t_valid)
    give_verdict();
  end

endmodule
